/* src/tws_cfg.svh */
`ifndef TWS_CFG_SVH
`define TWS_CFG_SVH
`define TWS_IDX_CTRL 8'h01
`define TWS_IDX_MODE 8'h02
`define TWS_IDX_PORT 8'h04
`define TWS_IDX_PIN 8'h05
`define TWS_IDX_SHIFT 8'h10
`define TWS_IDX_ENA 8'h2E
`define TWS_IDX_REQ 8'h3B
`define TWS_B_PINSEL 0
`define TWS_B_GIE 1
`define TWS_B_CKLO 0
`define TWS_B_CKHI 1
`define TWS_B_FLOAT 2
`define TWS_B_TS 3
`define TWS_B_REQ 0
`define TWS_B_ENA 0
`define TWS_B_DIR 4
`define TWS_PRIORITY 5
`define TWS_VECTOR 16'h0001
`define TWS_DIV16 16
`define TWS_DIV128 128
`define TWS_DIV1024 1024
`define TWS_LAST_BIT 3'h7
`define TWS_RST_BYTE 8'h00
`define TWS_RST_BIT 1'b0
`define TWS_RESP_OKAY 2'h0
`define TWS_RESP_SLVERR 2'h2
`endif

/* src/tws_pkg.sv */
package tws_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_ARM, ST_RUN} tws_state_e;
  typedef logic [1:0] tws_clksel_t;
endpackage : tws_pkg

/* src/tws_serial_shifter.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tws_cfg.svh"
module tws_serial_shifter (
  input wire logic sys_clk, // 25 MHz clock
  input wire logic resetn, // Async reset
  input wire logic [31:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [31:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic sckIn, // Clock pin level
  output logic sckOut, // Clock pin drive
  output logic sckOe, // Clock pin enable
  input wire logic soIn, // Output pin level
  output logic soOut, // Output pin drive
  output logic soOe, // Output pin enable
  input wire logic siIn, // Input pin level
  output logic siOut, // Input pin drive
  output logic siOe, // Input pin enable
  input wire logic standbyStop, // Oscillator stopped
  input wire logic irqAck, // Interrupt serviced
  output logic irq // Completion interrupt
);
  logic awHeld_r, awHeld_nxt, wHeld_r, wHeld_nxt, bvalid_r, bvalid_nxt;
  logic rvalid_r, rvalid_nxt, awready_r, awready_nxt, wready_r, wready_nxt;
  logic arready_r, arready_nxt, strb0_r, strb0_nxt;
  logic [7:0] awIdx_r, awIdx_nxt;
  logic [7:0] wData_r, wData_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic wrEn, rdFire;
  logic [7:0] rdIdx, rdByte;
  logic rdHit, wrHit;

  logic pinSel_r, pinSel_nxt, float_r, float_nxt, gie_r, gie_nxt;
  logic busy_r, busy_nxt, req_r, req_nxt, ena_r, ena_nxt;
  logic soLatch_r, soLatch_nxt, sck_r, sck_nxt, irq_r, irq_nxt;
  tws_pkg::tws_clksel_t ckSel_r, ckSel_nxt;
  tws_pkg::tws_state_e state_r, state_nxt;
  logic [7:0] shift_r, shift_nxt;
  logic [2:0] bitCnt_r, bitCnt_nxt;
  logic [9:0] div_r, div_nxt, halfDiv;
  logic [2:0] portOut_r, portOut_nxt, portDir_r, portDir_nxt;
  logic [2:0] pinO_r, pinO_nxt, pinOe_r, pinOe_nxt;
  logic [2:0] pinS1_r, pinS2_r;
  logic sckPrev_r;
  logic intSel, tick, fallEv, riseEv, siBit, startReq, doneEv;

  // Bus: address and data taken in either order, answer after both
  assign wrEn = awHeld_r && wHeld_r && !bvalid_r;
  assign rdFire = s_axi_arvalid && arready_r;
  assign rdIdx = s_axi_araddr[9:2];
  function automatic logic known(input logic [7:0] idx);
    known = idx == `TWS_IDX_CTRL || idx == `TWS_IDX_MODE ||
      idx == `TWS_IDX_PORT || idx == `TWS_IDX_PIN ||
      idx == `TWS_IDX_SHIFT || idx == `TWS_IDX_ENA ||
      idx == `TWS_IDX_REQ;
  endfunction : known
  assign rdHit = known(rdIdx);
  assign wrHit = known(awIdx_r);

  always_comb begin
    rdByte = 8'h00;
    unique case (rdIdx)
      `TWS_IDX_CTRL: rdByte = {6'h00, gie_r, pinSel_r};
      `TWS_IDX_MODE: rdByte = {4'h0, busy_r, float_r, ckSel_r};
      `TWS_IDX_PORT: rdByte = {1'b0, portDir_r, 1'b0, portOut_r};
      `TWS_IDX_PIN: rdByte = {5'h00, pinS2_r};
      `TWS_IDX_SHIFT: rdByte = shift_r;
      `TWS_IDX_ENA: rdByte = {7'h00, ena_r};
      `TWS_IDX_REQ: rdByte = {7'h00, req_r};
      default: rdByte = 8'h00;
    endcase
  end

  always_comb begin
    awHeld_nxt = awHeld_r;
    awIdx_nxt = awIdx_r;
    wHeld_nxt = wHeld_r;
    wData_nxt = wData_r;
    strb0_nxt = strb0_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (s_axi_awvalid && awready_r) begin
      awHeld_nxt = 1'b1;
      awIdx_nxt = s_axi_awaddr[9:2];
    end
    if (s_axi_wvalid && wready_r) begin
      wHeld_nxt = 1'b1;
      wData_nxt = s_axi_wdata[7:0];
      strb0_nxt = s_axi_wstrb[0];
    end
    if (wrEn) begin
      awHeld_nxt = 1'b0;
      wHeld_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = wrHit ? `TWS_RESP_OKAY : `TWS_RESP_SLVERR;
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (rdFire) begin
      rvalid_nxt = 1'b1;
      rdata_nxt = {24'h000000, rdByte};
      rresp_nxt = rdHit ? `TWS_RESP_OKAY : `TWS_RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    awready_nxt = !awHeld_nxt && !bvalid_nxt;
    wready_nxt = !wHeld_nxt && !bvalid_nxt;
    arready_nxt = !rvalid_nxt && !rdFire;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      awHeld_r <= 1'b0;
      awIdx_r <= 8'h00;
      wHeld_r <= 1'b0;
      wData_r <= 8'h00;
      strb0_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= 2'h0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= 2'h0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      arready_r <= 1'b0;
    end else begin
      awHeld_r <= awHeld_nxt;
      awIdx_r <= awIdx_nxt;
      wHeld_r <= wHeld_nxt;
      wData_r <= wData_nxt;
      strb0_r <= strb0_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      arready_r <= arready_nxt;
    end
  end

  // Clock source and edge events
  assign intSel = ckSel_r != 2'b00;
  always_comb begin
    unique case (ckSel_r)
      2'b01: halfDiv = 10'(`TWS_DIV16 / 2);
      2'b10: halfDiv = 10'(`TWS_DIV128 / 2);
      default: halfDiv = 10'(`TWS_DIV1024 / 2);
    endcase
  end
  // Internal divider is held at zero while the oscillator is stopped
  assign tick = intSel && !standbyStop && div_r == halfDiv - 10'h001;
  assign fallEv = intSel ? (tick && sck_r) : (sckPrev_r && !pinS2_r[0]);
  assign riseEv = intSel ? (tick && !sck_r) : (!sckPrev_r && pinS2_r[0]);
  assign siBit = pinS2_r[2];
  assign startReq = wrEn && strb0_r && awIdx_r == `TWS_IDX_MODE &&
    wData_r[`TWS_B_TS] && pinSel_r && state_r == tws_pkg::ST_IDLE;
  assign doneEv = state_r == tws_pkg::ST_RUN && riseEv &&
    bitCnt_r == `TWS_LAST_BIT;

  always_comb begin
    pinSel_nxt = pinSel_r;
    float_nxt = float_r;
    gie_nxt = gie_r;
    ckSel_nxt = ckSel_r;
    busy_nxt = busy_r;
    req_nxt = req_r;
    ena_nxt = ena_r;
    shift_nxt = shift_r;
    soLatch_nxt = soLatch_r;
    sck_nxt = sck_r;
    bitCnt_nxt = bitCnt_r;
    state_nxt = state_r;
    portOut_nxt = portOut_r;
    portDir_nxt = portDir_r;
    div_nxt = (tick || !intSel || standbyStop) ? 10'h000 : div_r + 10'h001;
    if (wrEn && strb0_r) begin
      unique case (awIdx_r)
        `TWS_IDX_CTRL: begin
          pinSel_nxt = wData_r[`TWS_B_PINSEL];
          gie_nxt = wData_r[`TWS_B_GIE];
        end
        `TWS_IDX_MODE: begin
          ckSel_nxt = {wData_r[`TWS_B_CKHI], wData_r[`TWS_B_CKLO]};
          float_nxt = wData_r[`TWS_B_FLOAT];
        end
        `TWS_IDX_PORT: begin
          portOut_nxt = wData_r[2:0];
          portDir_nxt = wData_r[`TWS_B_DIR +: 3];
        end
        `TWS_IDX_SHIFT: if (!busy_r) shift_nxt = wData_r;
        `TWS_IDX_ENA: ena_nxt = wData_r[`TWS_B_ENA];
        `TWS_IDX_REQ: if (wData_r[`TWS_B_REQ]) req_nxt = 1'b0;
        default: ;
      endcase
    end
    if (irqAck && irq_r) req_nxt = 1'b0;
    if (startReq) begin
      busy_nxt = 1'b1;
      req_nxt = 1'b0;
      bitCnt_nxt = 3'h0;
      state_nxt = tws_pkg::ST_ARM;
    end
    // Clock changes mid-byte only stretch or cut the running pulse
    unique case (state_r)
      tws_pkg::ST_IDLE: sck_nxt = 1'b1;
      tws_pkg::ST_ARM: if (fallEv) begin
        sck_nxt = 1'b0;
        soLatch_nxt = shift_r[7];
        state_nxt = tws_pkg::ST_RUN;
      end
      tws_pkg::ST_RUN: begin
        if (fallEv) begin
          sck_nxt = 1'b0;
          soLatch_nxt = shift_r[7];
        end else if (riseEv) begin
          sck_nxt = 1'b1;
          shift_nxt = {shift_r[6:0], siBit};
          bitCnt_nxt = bitCnt_r + 3'h1;
          if (doneEv) begin
            busy_nxt = 1'b0;
            req_nxt = 1'b1;
            state_nxt = tws_pkg::ST_IDLE;
          end
        end
      end
    endcase
    if (!pinSel_r && state_r != tws_pkg::ST_IDLE) begin
      busy_nxt = 1'b0;
      state_nxt = tws_pkg::ST_IDLE;
    end
  end

  // Pin muxing; the serial output latch never sees port writes
  always_comb begin
    pinO_nxt = portOut_r;
    pinOe_nxt = portDir_r;
    if (pinSel_r) begin
      pinO_nxt = {1'b0, soLatch_r, sck_r};
      pinOe_nxt = {1'b0, !float_r, intSel};
    end
    irq_nxt = req_r && ena_r && gie_r;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pinSel_r <= `TWS_RST_BIT;
      float_r <= `TWS_RST_BIT;
      gie_r <= `TWS_RST_BIT;
      ckSel_r <= 2'b00;
      busy_r <= `TWS_RST_BIT;
      req_r <= `TWS_RST_BIT;
      ena_r <= `TWS_RST_BIT;
      shift_r <= `TWS_RST_BYTE;
      soLatch_r <= `TWS_RST_BIT;
      sck_r <= 1'b1;
      bitCnt_r <= 3'h0;
      state_r <= tws_pkg::ST_IDLE;
      div_r <= 10'h000;
      portOut_r <= 3'h0;
      portDir_r <= 3'h0;
      pinO_r <= 3'h0;
      pinOe_r <= 3'h0;
      irq_r <= 1'b0;
      pinS1_r <= 3'h7;
      pinS2_r <= 3'h7;
      sckPrev_r <= 1'b1;
    end else begin
      pinSel_r <= pinSel_nxt;
      float_r <= float_nxt;
      gie_r <= gie_nxt;
      ckSel_r <= ckSel_nxt;
      busy_r <= busy_nxt;
      req_r <= req_nxt;
      ena_r <= ena_nxt;
      shift_r <= shift_nxt;
      soLatch_r <= soLatch_nxt;
      sck_r <= sck_nxt;
      bitCnt_r <= bitCnt_nxt;
      state_r <= state_nxt;
      div_r <= div_nxt;
      portOut_r <= portOut_nxt;
      portDir_r <= portDir_nxt;
      pinO_r <= pinO_nxt;
      pinOe_r <= pinOe_nxt;
      irq_r <= irq_nxt;
      pinS1_r <= {siIn, soIn, sckIn};
      pinS2_r <= pinS1_r;
      sckPrev_r <= pinS2_r[0];
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign {siOut, soOut, sckOut} = pinO_r;
  assign {siOe, soOe, sckOe} = pinOe_r;
  assign irq = irq_r;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  chk_start_arms: assert property (startReq |=>
    busy_r && state_r == tws_pkg::ST_ARM) else $error("start not armed");
  chk_start_clears: assert property (startReq |=> !req_r)
    else $error("start left request set");
  chk_msb_out: assert property (state_r != tws_pkg::ST_IDLE && fallEv
    |=> soLatch_r == $past(shift_r[7])) else $error("MSB not output");
  chk_shift_in: assert property (state_r == tws_pkg::ST_RUN && riseEv
    |=> shift_r[0] == $past(siBit) && shift_r[7:1] == $past(shift_r[6:0]))
    else $error("shift in wrong");
  chk_done_flags: assert property (doneEv |=> req_r && !busy_r)
    else $error("done flags wrong");
  chk_arm_count: assert property (state_r == tws_pkg::ST_ARM
    |-> bitCnt_r == 3'h0) else $error("counter not cleared");
  chk_idle_hold: assert property (!busy_r && !(wrEn &&
    awIdx_r == `TWS_IDX_SHIFT) |=> $stable(shift_r))
    else $error("idle register moved");
  chk_float_so: assert property (pinSel_r && float_r
    ##1 pinSel_r && float_r |-> !soOe) else $error("output not floated");
  chk_sck_drive: assert property (pinSel_r && intSel
    ##1 pinSel_r && intSel |-> sckOe) else $error("clock not driven");
  chk_standby_div: assert property (standbyStop && intSel
    |=> div_r == 10'h000) else $error("divider ran in standby");
  chk_ack_clear: assert property (irqAck && irq_r && !doneEv
    |=> !req_r) else $error("ack did not clear");
endmodule : tws_serial_shifter
`default_nettype wire

/* tb/tws_peer.sv */
`timescale 1ns/1ps
`default_nettype none
module tws_peer (
  input wire logic sys_clk, // System clock
  input wire logic sck, // Serial clock line
  input wire logic so, // Line from the device
  output logic si, // Line to the device
  output logic sckDrv, // Clock drive level
  output logic sckEn, // Clock drive enable
  output logic [7:0] rxByte // Last byte heard
);
  logic [7:0] txByte;
  int bitCnt;
  initial begin
    si = 1'b1;
    sckDrv = 1'b1;
    sckEn = 1'b0;
    txByte = 8'h00;
    rxByte = 8'h00;
    bitCnt = 0;
  end
  task automatic load(input logic [7:0] b);
    txByte = b;
    bitCnt = 0;
  endtask : load
  // Change after falling so the bit is settled at rising
  always @(negedge sck) begin
    si <= txByte[7];
  end
  always @(posedge sck) begin
    rxByte <= {rxByte[6:0], so};
    txByte <= {txByte[6:0], 1'b0};
    bitCnt = bitCnt + 1;
    if (bitCnt == 8) begin
      // Hold time over, the line stops showing the last bit
      repeat (4) @(posedge sys_clk);
      si <= ~si;
    end
  end
  // Clock stands high outside frames
  task automatic extByte(input int half);
    sckEn = 1'b1;
    repeat (8) begin
      @(posedge sys_clk);
      sckDrv <= 1'b0;
      repeat (half) @(posedge sys_clk);
      sckDrv <= 1'b1;
      repeat (half - 1) @(posedge sys_clk);
    end
    repeat (4) @(posedge sys_clk);
    sckEn = 1'b0;
  endtask : extByte
endmodule : tws_peer
`default_nettype wire

/* tb/tws_serial_shifter_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tws_cfg.svh"
module tws_serial_shifter_tb;
  logic sys_clk = 1'b0, resetn = 1'b0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp;
  logic sckOut, sckOe, soOut, soOe, siOut, siOe, irq, pSi, pSck, pSckEn;
  logic standbyStop = 0, irqAck = 0, soPark = 0, sckPrev = 1;
  logic [7:0] pRx, d, txD, txP;
  logic [7:0] modes [4] = '{8'h0D, 8'h09, 8'h0A, 8'h0B};
  int falls = 0, soOeCnt = 0, lowRun = 0, lowLen = 0, f0, o0;
  int miscompares = 0, checks = 0;
  wire sckLine = sckOe ? sckOut : (pSckEn ? pSck : 1'b1);
  wire soLine = soOe ? soOut : soPark;
  wire siLine = siOe ? siOut : pSi;
  always #20 sys_clk = ~sys_clk;
  tws_serial_shifter tws_serial_shifter_inst (.sys_clk(sys_clk),
    .resetn(resetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sckIn(sckLine), .sckOut(sckOut), .sckOe(sckOe), .soIn(soLine),
    .soOut(soOut), .soOe(soOe), .siIn(siLine), .siOut(siOut), .siOe(siOe),
    .standbyStop(standbyStop), .irqAck(irqAck), .irq(irq));
  tws_peer tws_peer_inst (.sys_clk(sys_clk), .sck(sckLine), .so(soLine),
    .si(pSi), .sckDrv(pSck), .sckEn(pSckEn), .rxByte(pRx));
  // Undriven output line wanders so a stale level cannot pass
  always @(posedge sys_clk) begin
    soPark <= ~soPark;
    sckPrev <= sckOut;
    if (sckPrev && !sckOut) falls <= falls + 1;
    if (soOe) soOeCnt <= soOeCnt + 1;
    if (!sckOut) lowRun <= lowRun + 1;
    else if (lowRun != 0) begin
      lowLen <= lowRun;
      lowRun <= 0;
    end
  end
  function automatic int halfOf(input logic [1:0] sel);
    case (sel)
      2'b01: return `TWS_DIV16 / 2;
      2'b10: return `TWS_DIV128 / 2;
      default: return `TWS_DIV1024 / 2;
    endcase
  endfunction : halfOf
  task automatic chk(input string what, input logic [7:0] e, logic [7:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic summarize();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize
  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    int n;
    @(posedge sys_clk);
    awaddr <= {22'h0, idx, 2'b00};
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 100);
    if (bvalid !== 1'b1) miscompares++;
    resp = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] idx, output logic [7:0] v);
    int n;
    @(posedge sys_clk);
    araddr <= {22'h0, idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 100);
    if (rvalid !== 1'b1) miscompares++;
    v = rdata[7:0];
    resp = rresp;
    rready <= 1'b0;
  endtask : rd
  task automatic waitIdle();
    int n;
    n = 0;
    do begin
      rd(`TWS_IDX_MODE, d);
      n++;
    end while (d[`TWS_B_TS] !== 1'b0 && n < 5000);
    // A transfer that never ends is a failure, not a skip
    if (d[`TWS_B_TS] !== 1'b0) miscompares++;
  endtask : waitIdle
  initial begin
    repeat (60000) @(posedge sys_clk);
    miscompares++;
    summarize();
  end
  initial begin
    void'($urandom(60274));
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk("irq", 0, irq);
    rd(8'h3F, d);
    chk("rresp", `TWS_RESP_SLVERR, resp);
    wr(8'h3F, 8'h01);
    chk("bresp", `TWS_RESP_SLVERR, resp);
    txD = $urandom;
    wr(`TWS_IDX_SHIFT, txD);
    wr(`TWS_IDX_MODE, 8'h09);
    rd(`TWS_IDX_MODE, d);
    chk("busy", 0, d[`TWS_B_TS]);
    rd(`TWS_IDX_SHIFT, d);
    chk("shift", txD, d);
    wr(`TWS_IDX_CTRL, 8'h03);
    // Pin mux is registered behind the control bit
    repeat (2) @(posedge sys_clk);
    chk("soOut", `TWS_RST_BIT, soOut);
    txD = $urandom;
    txP = $urandom;
    wr(`TWS_IDX_SHIFT, txD);
    tws_peer_inst.load(txP);
    wr(`TWS_IDX_MODE, 8'h08);
    standbyStop <= 1'b1;
    tws_peer_inst.extByte(10);
    waitIdle();
    rd(`TWS_IDX_SHIFT, d);
    chk("ext shift", txP, d);
    chk("ext rx", txD, pRx);
    rd(`TWS_IDX_REQ, d);
    chk("req", 1, d[`TWS_B_REQ]);
    chk("masked irq", 0, irq);
    wr(`TWS_IDX_MODE, 8'h09);
    repeat (300) @(posedge sys_clk);
    rd(`TWS_IDX_MODE, d);
    chk("stalled", 1, d[`TWS_B_TS]);
    wr(`TWS_IDX_CTRL, 8'h00);
    standbyStop <= 1'b0;
    rd(`TWS_IDX_MODE, d);
    chk("aborted", 0, d[`TWS_B_TS]);
    wr(`TWS_IDX_CTRL, 8'h03);
    wr(`TWS_IDX_ENA, 8'h01);
    repeat (2) @(posedge sys_clk);
    // The stalled start already wiped the request
    chk("irq", 0, irq);
    foreach (modes[i]) begin
      txD = $urandom;
      txP = $urandom;
      wr(`TWS_IDX_SHIFT, txD);
      tws_peer_inst.load(txP);
      wr(`TWS_IDX_MODE, modes[i]);
      // Snapshot once the float setting has reached the pin enable
      @(posedge sys_clk);
      f0 = falls;
      o0 = soOeCnt;
      rd(`TWS_IDX_REQ, d);
      chk("req cleared", 0, d[`TWS_B_REQ]);
      waitIdle();
      rd(`TWS_IDX_SHIFT, d);
      chk("shift", txP, d);
      chk("falls", 8, 8'(falls - f0));
      chk("half", 8'(halfOf(modes[i][1:0]) % 256),
          8'(lowLen % 256));
      chk("sckOe", 1, sckOe);
      chk("soOe", modes[i][2], 8'(soOeCnt == o0));
      if (!modes[i][2]) chk("rx", txD, pRx);
      if (!modes[i][2]) chk("so hold", txD[0], soOut);
      rd(`TWS_IDX_REQ, d);
      chk("req", 1, d[`TWS_B_REQ]);
      chk("irq", 1, irq);
    end
    @(posedge sys_clk);
    irqAck <= 1'b1;
    @(posedge sys_clk);
    irqAck <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk("irq ack", 0, irq);
    wr(`TWS_IDX_CTRL, 8'h00);
    wr(`TWS_IDX_PORT, 8'h75);
    repeat (2) @(posedge sys_clk);
    chk("port oe", 3'b111, {sckOe, soOe, siOe});
    chk("port out", 3'b101, {siOut, soOut, sckOut});
    rd(`TWS_IDX_PIN, d);
    chk("pin", 8'h05, d);
    wr(`TWS_IDX_CTRL, 8'h01);
    repeat (2) @(posedge sys_clk);
    chk("so latch", txD[0], soOut);
    summarize();
  end
endmodule : tws_serial_shifter_tb
`default_nettype wire
